// file: rtl/ea_pkg.sv
package ea_pkg;
   localparam logic [7:0] OFF_INSTR  = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_EA     = 8'h08;
   localparam logic [7:0] OFF_OPLO   = 8'h0C;
   localparam logic [7:0] OFF_OPHI   = 8'h10;
   localparam logic [7:0] OFF_SDATA  = 8'h14;
   localparam logic [7:0] OFF_BFN    = 8'h18;
   localparam logic [7:0] OFF_INDEX  = 8'h20;

   localparam int F_IND  = 16;
   localparam int F_XSEL = 17;
   localparam int F_CLS  = 20;
   localparam int F_IMM  = 23;
   localparam int F_HALF = 24;
   localparam int F_SIZE = 25;
   localparam int F_POS  = 28;

   localparam int S_BUSY = 0;
   localparam int S_DONE = 1;
   localparam int S_NOP  = 2;
   localparam int S_NEG  = 3;

   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [15:0] HALF_RST = 16'h0000;
   localparam logic [3:0]  BFN_RST  = 4'hC;

   typedef enum logic [2:0] {
      CLS_LOAD   = 3'h0,
      CLS_HALF   = 3'h1,
      CLS_DOUBLE = 3'h2,
      CLS_STORE  = 3'h3,
      CLS_STHALF = 3'h4,
      CLS_BOOL   = 3'h5,
      CLS_SHIFT  = 3'h6,
      CLS_ADDR   = 3'h7
   } cls_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_IND   = 3'h1,
      ST_READ  = 3'h2,
      ST_READ2 = 3'h3,
      ST_WRITE = 3'h4
   } state_type;

   function automatic logic [15:0] add16(input logic [15:0] a,
                                         input logic [15:0] b);
      return a + b;
   endfunction

   function automatic logic [31:0] sext(input logic [15:0] h);
      return {{16{h[15]}}, h};
   endfunction

   // left half is the upper sixteen bits
   function automatic logic [15:0] half_of(input logic [31:0] w,
                                           input logic        right);
      return right ? w[15:0] : w[31:16];
   endfunction

   function automatic logic [31:0] put_half(input logic [31:0] w,
                                            input logic        right,
                                            input logic [15:0] h);
      return right ? {w[31:16], h} : {h, w[15:0]};
   endfunction

   // byte position counts from the low end; out of range gives no bits
   function automatic logic [15:0] byte_mask(input logic [2:0] size,
                                             input logic [3:0] pos);
      logic [4:0]  w;
      logic [16:0] ones;
      logic [8:0]  sh;
      w    = (size > 3'h4) ? 5'h01 : (5'h10 >> size);
      ones = (17'h00001 << w) - 17'h00001;
      sh   = {5'h00, pos} * {4'h0, w};
      return ones[15:0] << sh;
   endfunction

   function automatic logic [15:0] bool_apply(input logic [3:0]  fn,
                                              input logic [15:0] a,
                                              input logic [15:0] m,
                                              input logic [15:0] mask);
      logic [15:0] r;
      for (int i = 0; i < 16; i++)
      begin
         r[i] = mask[i] ? fn[{a[i], m[i]}] : m[i];
      end
      return r;
   endfunction

   function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      for (int i = 0; i < 4; i++)
      begin
         r[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      return r;
   endfunction
endpackage

// file: rtl/effective_address_generator.sv
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module effective_address_generator (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic      [15:0] mem_addr_o,
   output logic      [31:0] mem_wdata_o,
   input  wire logic [31:0] mem_rdata_i,
   input  wire logic        mem_ack_i,
   output logic             busy_o
);
   ea_pkg::state_type st_reg, st_next;
   ea_pkg::cls_type   cls;
   logic [31:0] instr_reg, instr_next, sdata_reg, sdata_next;
   logic [31:0] wdata_reg, wdata_next, oplo_reg, oplo_next;
   logic [31:0] ophi_reg, ophi_next, dat_reg, dat_next;
   logic [15:0] ea_reg, ea_next, addr_reg, addr_next;
   logic [3:0]  bfn_reg, bfn_next;
   logic        done_reg, done_next, nop_reg, nop_next;
   logic        neg_reg, neg_next, ack_reg, ack_next;
   logic        wb_req, wb_wr, start, sw_idx, fin, clr, hsel;
   logic [31:0] cur, instr_in, status, idx_w;
   logic [15:0] base, mfield, xval, ind_addr, bmask, hword;
   logic [7:0]  wadr;

   index_if ix ();

   index_file u_index (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .ix    (ix)
   );

   function automatic ea_pkg::state_type access(input ea_pkg::cls_type c);
      case (c)
         ea_pkg::CLS_STORE: return ea_pkg::ST_WRITE;
         ea_pkg::CLS_ADDR:  return ea_pkg::ST_IDLE;
         default:           return ea_pkg::ST_READ;
      endcase
   endfunction

   assign wadr     = {wb_adr_i[7:2], 2'b00};
   assign wb_req   = wb_cyc_i & wb_stb_i;
   // writes land on the edge where the master sees ack
   assign wb_wr    = wb_req & wb_we_i & ack_reg;
   assign instr_in = ea_pkg::apply_sel(instr_reg, wb_dat_i, wb_sel_i);
   // a new instruction is refused while a sequence is running
   assign start    = wb_wr && wadr == ea_pkg::OFF_INSTR &&
                     st_reg == ea_pkg::ST_IDLE;
   assign cur      = start ? instr_in : instr_reg;
   assign cls      = ea_pkg::cls_type'(cur[ea_pkg::F_CLS +: 3]);
   assign mfield   = cur[15:0];
   assign hsel     = cur[ea_pkg::F_HALF];
   assign sw_idx   = wb_adr_i[7:5] == ea_pkg::OFF_INDEX[7:5];
   assign clr      = wb_wr && wadr == ea_pkg::OFF_STATUS &&
                     wb_sel_i[0] && wb_dat_i[ea_pkg::S_DONE];
   assign idx_w    = ea_pkg::apply_sel({16'h0000, ix.sw_val}, wb_dat_i,
                                       wb_sel_i);
   assign ix.ea_sel  = cur[ea_pkg::F_XSEL +: 3];
   assign ix.sw_sel  = wb_adr_i[4:2];
   assign ix.wr_en   = wb_wr & sw_idx;
   assign ix.wr_sel  = wb_adr_i[4:2];
   assign ix.wr_data = idx_w[15:0];
   assign xval       = ix.ea_val;
   // index is added before any indirect fetch or immediate use
   assign base     = ea_pkg::add16(mfield, xval);
   assign ind_addr = mem_rdata_i[15:0];
   assign hword    = ea_pkg::half_of(mem_rdata_i, hsel);
   assign bmask    = ea_pkg::byte_mask(cur[ea_pkg::F_SIZE +: 3],
                                       cur[ea_pkg::F_POS +: 4]);

   always_comb
   begin
      status = ea_pkg::WORD_RST;
      status[ea_pkg::S_BUSY] = st_reg != ea_pkg::ST_IDLE;
      status[ea_pkg::S_DONE] = done_reg;
      status[ea_pkg::S_NOP]  = nop_reg;
      status[ea_pkg::S_NEG]  = neg_reg;
   end

   always_comb
   begin
      instr_next = start ? instr_in : instr_reg;
      sdata_next = sdata_reg;
      bfn_next   = bfn_reg;
      ack_next   = wb_req & ~ack_reg;
      dat_next   = dat_reg;
      if (wb_wr && wadr == ea_pkg::OFF_SDATA)
         sdata_next = ea_pkg::apply_sel(sdata_reg, wb_dat_i, wb_sel_i);
      if (wb_wr && wadr == ea_pkg::OFF_BFN && wb_sel_i[0])
         bfn_next = wb_dat_i[3:0];
      if (wb_req && !ack_reg)
      begin
         case (wadr)
            ea_pkg::OFF_INSTR:  dat_next = instr_reg;
            ea_pkg::OFF_STATUS: dat_next = status;
            ea_pkg::OFF_EA:     dat_next = {16'h0000, ea_reg};
            ea_pkg::OFF_OPLO:   dat_next = oplo_reg;
            ea_pkg::OFF_OPHI:   dat_next = ophi_reg;
            ea_pkg::OFF_SDATA:  dat_next = sdata_reg;
            ea_pkg::OFF_BFN:    dat_next = {28'h0000000, bfn_reg};
            default:
               dat_next = sw_idx ? {16'h0000, ix.sw_val} : ea_pkg::WORD_RST;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         instr_reg <= ea_pkg::WORD_RST;
         sdata_reg <= ea_pkg::WORD_RST;
         bfn_reg   <= ea_pkg::BFN_RST;
         ack_reg   <= 1'b0;
         dat_reg   <= ea_pkg::WORD_RST;
      end
      else if (ce_i)
      begin
         instr_reg <= instr_next;
         sdata_reg <= sdata_next;
         bfn_reg   <= bfn_next;
         ack_reg   <= ack_next;
         dat_reg   <= dat_next;
      end
   end

   always_comb
   begin
      st_next    = st_reg;
      ea_next    = ea_reg;
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      oplo_next  = oplo_reg;
      ophi_next  = ophi_reg;
      nop_next   = nop_reg;
      neg_next   = neg_reg;
      fin        = 1'b0;
      case (st_reg)
         ea_pkg::ST_IDLE:
            if (start)
            begin
               ea_next    = base;
               addr_next  = base;
               nop_next   = 1'b0;
               neg_next   = 1'b0;
               wdata_next = sdata_reg;
               if (cur[ea_pkg::F_IMM])
               begin
                  // operand is the instruction field plus index, no memory cycle
                  oplo_next = ea_pkg::sext(base);
                  neg_next  = base[15];
                  nop_next  = cls == ea_pkg::CLS_STORE ||
                              cls == ea_pkg::CLS_STHALF ||
                              cls == ea_pkg::CLS_BOOL;
                  fin       = 1'b1;
               end
               else if (cur[ea_pkg::F_IND])
                  st_next = ea_pkg::ST_IND;
               else
               begin
                  st_next = access(cls);
                  fin     = access(cls) == ea_pkg::ST_IDLE;
               end
            end
         ea_pkg::ST_IND:
            if (mem_ack_i)
            begin
               ea_next   = ind_addr;
               addr_next = ind_addr;
               if (!mem_rdata_i[ea_pkg::F_IND])
               begin
                  st_next = access(cls);
                  fin     = access(cls) == ea_pkg::ST_IDLE;
               end
            end
         ea_pkg::ST_READ:
            if (mem_ack_i)
            begin
               case (cls)
                  ea_pkg::CLS_HALF:
                  begin
                     oplo_next = {16'h0000, hword};
                     fin       = 1'b1;
                  end
                  ea_pkg::CLS_DOUBLE:
                  begin
                     ophi_next = mem_rdata_i;
                     addr_next = ea_pkg::add16(ea_reg, 16'h0001);
                     st_next   = ea_pkg::ST_READ2;
                  end
                  ea_pkg::CLS_SHIFT:
                  begin
                     oplo_next = mem_rdata_i;
                     neg_next  = mem_rdata_i[31];
                     fin       = 1'b1;
                  end
                  ea_pkg::CLS_STHALF:
                  begin
                     wdata_next = ea_pkg::put_half(mem_rdata_i, hsel,
                                                   sdata_reg[15:0]);
                     st_next    = ea_pkg::ST_WRITE;
                  end
                  ea_pkg::CLS_BOOL:
                  begin
                     wdata_next = ea_pkg::put_half(mem_rdata_i, hsel,
                        ea_pkg::bool_apply(bfn_reg, sdata_reg[15:0],
                                           hword, bmask));
                     st_next    = ea_pkg::ST_WRITE;
                  end
                  default:
                  begin
                     oplo_next = mem_rdata_i;
                     fin       = 1'b1;
                  end
               endcase
            end
         ea_pkg::ST_READ2:
            if (mem_ack_i)
            begin
               oplo_next = mem_rdata_i;
               fin       = 1'b1;
            end
         ea_pkg::ST_WRITE:
            fin = mem_ack_i;
         default:
            st_next = ea_pkg::ST_IDLE;
      endcase
      if (fin)
         st_next = ea_pkg::ST_IDLE;
      done_next = done_reg;
      if (clr || start)
         done_next = 1'b0;
      // completion wins over a clear in the same cycle
      if (fin)
         done_next = 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg    <= ea_pkg::ST_IDLE;
         ea_reg    <= ea_pkg::HALF_RST;
         addr_reg  <= ea_pkg::HALF_RST;
         wdata_reg <= ea_pkg::WORD_RST;
         oplo_reg  <= ea_pkg::WORD_RST;
         ophi_reg  <= ea_pkg::WORD_RST;
         done_reg  <= 1'b0;
         nop_reg   <= 1'b0;
         neg_reg   <= 1'b0;
      end
      else if (ce_i)
      begin
         st_reg    <= st_next;
         ea_reg    <= ea_next;
         addr_reg  <= addr_next;
         wdata_reg <= wdata_next;
         oplo_reg  <= oplo_next;
         ophi_reg  <= ophi_next;
         done_reg  <= done_next;
         nop_reg   <= nop_next;
         neg_reg   <= neg_next;
      end
   end

   assign wb_dat_o    = dat_reg;
   assign wb_ack_o    = ack_reg;
   assign mem_req_o   = st_reg != ea_pkg::ST_IDLE;
   assign mem_we_o    = st_reg == ea_pkg::ST_WRITE;
   assign mem_addr_o  = addr_reg;
   assign mem_wdata_o = wdata_reg;
   assign busy_o      = st_reg != ea_pkg::ST_IDLE;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_direct_addr: assert property (start && ce_i && !cur[ea_pkg::F_IMM] &&
      !cur[ea_pkg::F_IND] && ix.ea_sel == 3'h0 && cls != ea_pkg::CLS_ADDR
      |=> mem_req_o && mem_addr_o == $past(mfield))
      else $error("direct address not used unchanged");
   a_index_sum: assert property (start && ce_i && ix.ea_sel != 3'h0
      |=> ea_reg == $past(mfield) + $past(xval))
      else $error("effective address is not field plus index");
   a_imm_operand: assert property (start && ce_i && cur[ea_pkg::F_IMM]
      |=> !mem_req_o && done_reg && oplo_reg[15:0] == $past(base) &&
      oplo_reg[31:16] == {16{oplo_reg[15]}})
      else $error("immediate operand wrong or memory touched");
   a_store_nop: assert property (start && ce_i && cur[ea_pkg::F_IMM] &&
      cls == ea_pkg::CLS_STORE |=> (nop_reg && !mem_we_o) [*2])
      else $error("immediate store was not a no-operation");
   a_chain_go: assert property (st_reg == ea_pkg::ST_IND && mem_ack_i &&
      ce_i && mem_rdata_i[ea_pkg::F_IND] |=> st_reg == ea_pkg::ST_IND &&
      mem_addr_o == $past(ind_addr))
      else $error("indirect chain did not follow the fetched word");
   a_chain_end: assert property (st_reg == ea_pkg::ST_IND && mem_ack_i &&
      ce_i && !mem_rdata_i[ea_pkg::F_IND] |=> st_reg != ea_pkg::ST_IND)
      else $error("indirect chain did not stop");
   a_double_next: assert property (st_reg == ea_pkg::ST_READ && ce_i &&
      mem_ack_i && cls == ea_pkg::CLS_DOUBLE |=> st_reg == ea_pkg::ST_READ2
      && mem_addr_o == $past(mem_addr_o) + 16'h0001)
      else $error("second word of double not at next address");
   a_half_keep: assert property (st_reg == ea_pkg::ST_READ && ce_i &&
      mem_ack_i && cls == ea_pkg::CLS_STHALF |=>
      ea_pkg::half_of(mem_wdata_o, !hsel) ==
      ea_pkg::half_of($past(mem_rdata_i), !hsel) &&
      ea_pkg::half_of(mem_wdata_o, hsel) == sdata_reg[15:0])
      else $error("half store disturbed the other half");
   a_bool_mask: assert property (st_reg == ea_pkg::ST_READ && ce_i &&
      mem_ack_i && cls == ea_pkg::CLS_BOOL |=>
      ((mem_wdata_o ^ $past(mem_rdata_i)) &
      ~ea_pkg::put_half(32'h0000_0000, hsel, bmask)) == 32'h0000_0000)
      else $error("byte operation changed bits outside the byte");
   a_wb_ack: assert property (wb_req && !ack_reg && ce_i
      |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle after request");

   c_two_level: cover property (st_reg == ea_pkg::ST_IND && mem_ack_i &&
      mem_rdata_i[ea_pkg::F_IND] ##1 st_reg == ea_pkg::ST_IND && mem_ack_i);
   c_double: cover property (st_reg == ea_pkg::ST_READ2 && mem_ack_i);
   c_bool: cover property (st_reg == ea_pkg::ST_WRITE &&
      cls == ea_pkg::CLS_BOOL && mem_ack_i);
   c_imm_shift: cover property (start && cur[ea_pkg::F_IMM] &&
      cls == ea_pkg::CLS_SHIFT);
endmodule

// file: rtl/index_file.sv
`timescale 1ns/1ps
module index_file (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   index_if.file     ix
);
   logic [15:0]  x_reg  [1:7];
   logic [15:0]  x_next [1:7];
   logic [111:0] flat;

   function automatic logic [15:0] pick(input logic [2:0] s);
      return (s == 3'h0) ? ea_pkg::HALF_RST : x_reg[s];
   endfunction

   // only a software write changes an entry; address forming never does
   always_comb
   begin
      for (int i = 1; i < 8; i++)
      begin
         x_next[i] = x_reg[i];
      end
      if (ix.wr_en && ix.wr_sel != 3'h0)
      begin
         x_next[ix.wr_sel] = ix.wr_data;
      end
   end

   always_ff @(posedge clk_i)
   begin
      for (int i = 1; i < 8; i++)
      begin
         if (rst_i)
            x_reg[i] <= ea_pkg::HALF_RST;
         else if (ce_i)
            x_reg[i] <= x_next[i];
      end
   end

   // entry one is the accumulator's upper section
   assign ix.ea_val = pick(ix.ea_sel);
   assign ix.sw_val = pick(ix.sw_sel);
   assign flat = {x_reg[7], x_reg[6], x_reg[5], x_reg[4],
                  x_reg[3], x_reg[2], x_reg[1]};

   a_index_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !ix.wr_en |=> $stable(flat))
      else $error("index register changed without a write");
   a_sel_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      ix.ea_sel == 3'h0 |-> ix.ea_val == 16'h0000)
      else $error("selector zero gave a nonzero index");
   a_sel_acc: assert property (@(posedge clk_i) disable iff (rst_i)
      ix.ea_sel == 3'h1 |-> ix.ea_val == flat[15:0])
      else $error("selector one did not pick the accumulator section");
endmodule

// file: rtl/index_if.sv
`timescale 1ns/1ps
interface index_if;
   logic [2:0]  ea_sel;
   logic [15:0] ea_val;
   logic [2:0]  sw_sel;
   logic [15:0] sw_val;
   logic        wr_en;
   logic [2:0]  wr_sel;
   logic [15:0] wr_data;
   modport file (input ea_sel, sw_sel, wr_en, wr_sel, wr_data,
                 output ea_val, sw_val);
   modport user (output ea_sel, sw_sel, wr_en, wr_sel, wr_data,
                 input ea_val, sw_val);
endinterface

// file: test/core_memory_model.sv
`timescale 1ns/1ps
module core_memory_model (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [1:0]  wait_i,
   output logic      [31:0] rdata_o = 32'h0000_0000,
   output logic             ack_o = 1'h0
);
   // 1k words alias over the whole 16-bit address space
   logic [31:0] mem [0:1023];
   int          cnt = 0;
   int          n_acc = 0;
   int          n_wr = 0;
   // read data toggles outside the ack cycle so stale values never pass
   always @(posedge clk_i)
   begin
      rdata_o <= ~rdata_o;
      ack_o <= 1'h0;
      if (req_i && !ack_o && cnt >= wait_i)
      begin
         ack_o <= 1'h1;
         cnt <= 0;
         n_acc <= n_acc + 1;
         if (we_i)
         begin
            mem[addr_i[9:0]] <= wdata_i;
            n_wr <= n_wr + 1;
         end
         else
            rdata_o <= mem[addr_i[9:0]];
      end
      else if (req_i && !ack_o)
         cnt <= cnt + 1;
   end
endmodule

// file: test/tb_effective_address_generator.sv
`timescale 1ns/1ps
module tb_effective_address_generator;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc = 1'h0;
   logic        we = 1'h0;
   logic        ack, req, mwe, mack, busy;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdo, rd, mwd, mrd;
   logic [15:0] madr;
   logic [1:0]  wt = 2'h0;
   logic [15:0] lfsr = 16'h004E;
   logic [15:0] x [0:7];
   int          error_cnt = 0;
   int          cmp_count = 0;
   always #50 clk_i = ~clk_i;
   effective_address_generator effective_address_generator_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .mem_req_o(req),
      .mem_we_o(mwe), .mem_addr_o(madr), .mem_wdata_o(mwd),
      .mem_rdata_i(mrd), .mem_ack_i(mack), .busy_o(busy));
   core_memory_model core_memory_model_i (
      .clk_i(clk_i), .req_i(req), .we_i(mwe), .addr_i(madr),
      .wdata_i(mwd), .wait_i(wt), .rdata_o(mrd), .ack_o(mack));
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function automatic logic [31:0] m(input logic [15:0] a);
      return core_memory_model_i.mem[a[9:0]];
   endfunction
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 5000)
      begin
         error_cnt++;
         $display("mismatch t=%0t timeout", $time);
         report_and_stop();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      dat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'h1 && n < 5000);
      tmo(n);
      rd = rdo;
      cyc <= 1'h0;
      we <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic one(input logic [31:0] ins);
      logic [15:0] a, h;
      logic [31:0] w, lo, nw, sd;
      logic [3:0]  fn;
      logic [2:0]  c;
      logic        ind, st;
      int          acc, wr, n, wd, lv;
      sd = {rnd(), rnd()};
      fn = 4'(rnd());
      bus(1'h1, ea_pkg::OFF_SDATA, sd);
      bus(1'h1, ea_pkg::OFF_BFN, {28'h0000000, fn});
      c = ins[22:20];
      st = c inside {3'h3, 3'h4, 3'h5};
      ind = ins[16] && !ins[23];
      a = ins[15:0] + x[ins[19:17]];
      acc = core_memory_model_i.n_acc;
      wr = core_memory_model_i.n_wr + int'(st && !ins[23]);
      // a chain longer than the memory must loop, so bound the model walk
      lv = 0;
      while (ind && lv < 1100)
      begin
         w = m(a);
         a = w[15:0];
         ind = w[16];
         acc++;
         lv++;
      end
      tmo(lv >= 1100 ? 5000 : 0);
      w = m(a);
      h = ins[24] ? w[15:0] : w[31:16];
      lo = ins[23] ? {{16{a[15]}}, a} : w;
      if (!ins[23])
         acc += (c == 3'h7) ? 0 : (c == 3'h2 || c == 3'h4 || c == 3'h5) + 1;
      if (c == 3'h1 && !ins[23])
         lo = {16'h0000, h};
      if (c == 3'h2 && !ins[23])
         lo = m(a + 16'h0001);
      if (c == 3'h4)
         h = sd[15:0];
      wd = (ins[27:25] > 3'h4) ? 1 : 16 >> ins[27:25];
      for (int i = 0; i < 16; i++)
         if (c == 3'h5 && i / wd == ins[31:28])
            h[i] = fn[{sd[i], h[i]}];
      nw = (c == 3'h3) ? sd : ins[24] ? {w[31:16], h} : {h, w[15:0]};
      bus(1'h1, ea_pkg::OFF_INSTR, ins);
      n = 0;
      while (busy !== 1'h0 && n < 5000)
      begin
         @(posedge clk_i);
         n++;
      end
      tmo(n);
      bus(1'h0, ea_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[2:0]), {29'h0, ins[23] && st, 2'h2});
      if (c == 3'h6)
         chk(32'(rd[3]), 32'(ins[23] ? a[15] : w[31]));
      chk(core_memory_model_i.n_acc, acc);
      chk(core_memory_model_i.n_wr, wr);
      bus(1'h0, ea_pkg::OFF_EA, 32'h0);
      if (!ins[23])
         chk(rd, {16'h0000, a});
      bus(1'h0, ea_pkg::OFF_OPLO, 32'h0);
      if (ins[23] ? !st : c < 3'h3)
         chk(rd, lo);
      bus(1'h0, ea_pkg::OFF_OPHI, 32'h0);
      if (c == 3'h2 && !ins[23])
         chk(rd, w);
      if (st && !ins[23])
         chk(m(a), nw);
   endtask
   initial
   begin
      logic [31:0] ins;
      for (int i = 0; i < 8; i++)
         x[i] = 16'h0000;
      for (int i = 0; i < 1024; i++)
         core_memory_model_i.mem[i] = {rnd(), 16'(i + 1)};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      bus(1'h0, ea_pkg::OFF_INDEX, 32'h0);
      chk(rd, 32'h0);
      bus(1'h0, ea_pkg::OFF_INDEX + 8'h04, 32'h0);
      chk(rd, 32'h0);
      for (int n = 1; n < 8; n++)
      begin
         x[n] = rnd();
         bus(1'h1, ea_pkg::OFF_INDEX + 8'(4 * n), {16'h0000, x[n]});
      end
      $display("test reset and index setup done");
      // every class with and without immediate, at four memory speeds
      for (int k = 0; k < 64; k++)
      begin
         ins = {rnd(), rnd()};
         ins[23:20] = 4'(k);
         wt <= 2'(k / 16);
         one(ins);
      end
      $display("test address modes done");
      for (int n = 1; n < 8; n++)
      begin
         bus(1'h0, ea_pkg::OFF_INDEX + 8'(4 * n), 32'h0);
         chk(rd, {16'h0000, x[n]});
      end
      $display("test index retention done");
      report_and_stop();
   end
endmodule
